// *** rtl/risq_regs.svh ***
`ifndef RISQ_REGS_SVH
`define RISQ_REGS_SVH

// ----------------------------------------------------------------
// timing figures, in sync clock periods unless named otherwise
// ----------------------------------------------------------------
`define RISQ_CLK_PERIOD_NS   10
`define RISQ_IN_QUAL_CYC     32
`define RISQ_POR_QUAL_CYC    32
`define RISQ_OUT_ASSERT_CYC  512
`define RISQ_HS_GAP_CYC      16
`define RISQ_STRAP_SETUP_CYC 4
`define RISQ_STRAP_HOLD_NS   0
`define RISQ_STRAP_OFF_NS    4
`define RISQ_STRAP_ON_CYC    1
`define RISQ_DLL_MIN_CYC     7680
`define RISQ_DLL_MAX_CYC     122880

// ----------------------------------------------------------------
// field positions of the synchronised pin word
// ----------------------------------------------------------------
`define RISQ_SYN_W           8
`define RISQ_SYN_POR         0
`define RISQ_SYN_HARD        1
`define RISQ_SYN_SOFT        2
`define RISQ_SYN_HOST        3
`define RISQ_SYN_DIV         4
`define RISQ_SYN_SRC_LO      5
`define RISQ_SYN_SRC_HI      7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RISQ_SYN_RST         8'h0f
`define RISQ_SRC_RST         3'h0
`define RISQ_DIV_RST         1'h0
`define RISQ_RATIO_RST       2'h0

`endif

// *** rtl/risq_pkg.sv ***
package risq_pkg;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RISQ_IDLE  = 4'b0001,
    RISQ_DRIVE = 4'b0010,
    RISQ_GAP   = 4'b0100,
    RISQ_DLL   = 4'b1000
  } risq_state_t;

  // ----------------------------------------------------------------
  // all state of the sequencer
  // ----------------------------------------------------------------
  typedef struct packed {
    risq_state_t state;
    logic [16:0] cnt;
    logic [5:0]  hard_q;
    logic [5:0]  soft_q;
    logic [5:0]  por_q;
    logic        por_valid;
    logic        por_prev;
    logic        soft_only;
    logic        hard_drive;
    logic        soft_drive;
    logic [2:0]  src_cap;
    logic        div_cap;
    logic        host_cap;
    logic [1:0]  ratio;
    logic        strap_drive;
    logic [1:0]  strap_cnt;
    logic        dll_locked;
  } risq_regs_t;

endpackage

// *** rtl/risq_sync.sv ***
`timescale 1ns/1ps
`include "risq_regs.svh"

// two-flop synchroniser; the first stage feeds only the second
module risq_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // ----------------------------------------------------------------
  // crossing stages
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RST;
      q        <= RST;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// *** rtl/risq_top.sv ***
`timescale 1ns/1ps
`include "risq_regs.svh"

// Behaviour
// - hard/soft reset input must stay low 32 sync periods before a flow starts.
// - driven hard/soft reset outputs stay low at least 512 sync periods.
// - hard reset released first, soft reset at least 16 periods later.
// - strap pin drivers turn off within 4 ns of hard reset assertion.
// - strap pin drivers return no sooner than 1 sync period after hard release.
// - DLL lock takes 7680 to 122880 sync periods, by clock ratio.
// - host mode sync clock period follows the captured divider strap.
// - reset pins are only pulled low or released, never driven high.
module risq_top #(
  parameter int DLL_LOCK_MIN_CYCLES = `RISQ_DLL_MIN_CYC,
  parameter int DLL_LOCK_MAX_CYCLES = `RISQ_DLL_MAX_CYC
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  input  wire logic       power_on_reset_n,
  input  wire logic       hard_reset_n_in,
  output logic            hard_reset_n_out,
  output logic            hard_reset_n_oe,
  input  wire logic       soft_reset_n_in,
  output logic            soft_reset_n_out,
  output logic            soft_reset_n_oe,
  input  wire logic       pci_host_mode,
  input  wire logic [2:0] reset_source_in,
  output logic      [2:0] reset_source_out,
  output logic            reset_source_oe,
  input  wire logic       input_clock_divide_select_in,
  output logic            input_clock_divide_select_out,
  output logic            input_clock_divide_select_oe,
  input  wire logic       hard_reset_req,
  input  wire logic       soft_reset_req,
  input  wire logic [1:0] dll_ratio_sel,
  output logic      [2:0] captured_reset_source,
  output logic            captured_clock_divide,
  output logic            sync_clock_divided,
  output logic            dll_locked,
  output logic            flow_busy
);

  // ----------------------------------------------------------------
  // derived counts
  // ----------------------------------------------------------------
  localparam logic [16:0] IN_QUAL  = 17'(`RISQ_IN_QUAL_CYC);
  localparam logic [16:0] POR_QUAL = 17'(`RISQ_POR_QUAL_CYC);
  localparam logic [16:0] OUT_LOW  = 17'(`RISQ_OUT_ASSERT_CYC);
  localparam logic [16:0] HS_GAP   = 17'(`RISQ_HS_GAP_CYC);
  localparam logic [1:0]  STRAP_ON = 2'(`RISQ_STRAP_ON_CYC);
  localparam logic [16:0] DLL_MIN  = 17'(DLL_LOCK_MIN_CYCLES);
  localparam logic [16:0] DLL_MAX  = 17'(DLL_LOCK_MAX_CYCLES);

  risq_pkg::risq_regs_t  r_reg;
  risq_pkg::risq_regs_t  r_next;
  logic [`RISQ_SYN_W-1:0] pin_raw;
  logic [`RISQ_SYN_W-1:0] pin_syn;
  logic                   por_low;
  logic                   hard_low_ext;
  logic                   soft_low_ext;
  logic                   hard_hit;
  logic                   soft_hit;
  logic                   por_release;
  logic                   hard_start;
  logic                   soft_start;
  logic [16:0]            dll_limit;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {reset_source_in, input_clock_divide_select_in, pci_host_mode,
                    soft_reset_n_in, hard_reset_n_in, power_on_reset_n};

  risq_sync #(
    .W   (`RISQ_SYN_W),
    .RST (`RISQ_SYN_RST)
  ) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .d       (pin_raw),
    .q       (pin_syn)
  );

  // ----------------------------------------------------------------
  // decoded pin events
  // ----------------------------------------------------------------
  // our own drive also pulls the pins low, so it is not counted as an outside request
  assign por_low      = ~pin_syn[`RISQ_SYN_POR];
  assign hard_low_ext = ~pin_syn[`RISQ_SYN_HARD] & ~r_reg.hard_drive;
  assign soft_low_ext = ~pin_syn[`RISQ_SYN_SOFT] & ~r_reg.soft_drive;
  assign hard_hit     = hard_low_ext & (17'(r_reg.hard_q) == IN_QUAL - 17'd1);
  assign soft_hit     = soft_low_ext & (17'(r_reg.soft_q) == IN_QUAL - 17'd1);
  assign por_release  = ~por_low & r_reg.por_prev & r_reg.por_valid;
  assign hard_start   = hard_hit | hard_reset_req;
  assign soft_start   = soft_hit | soft_reset_req;

  // lock time scales with the square of the ratio over 2:1
  always_comb begin
    case (r_reg.ratio)
      2'd0:    dll_limit = DLL_MIN;
      2'd1:    dll_limit = 17'(DLL_MIN << 2);
      default: dll_limit = 17'(DLL_MIN << 4);
    endcase
    if (dll_limit > DLL_MAX) begin
      dll_limit = DLL_MAX;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next          = r_reg;
    r_next.por_prev = por_low;

    // qualification counters saturate one short of wrapping
    if (hard_low_ext && r_reg.hard_q != 6'h3f) begin
      r_next.hard_q = r_reg.hard_q + 6'd1;
    end else if (!hard_low_ext) begin
      r_next.hard_q = 6'd0;
    end
    if (soft_low_ext && r_reg.soft_q != 6'h3f) begin
      r_next.soft_q = r_reg.soft_q + 6'd1;
    end else if (!soft_low_ext) begin
      r_next.soft_q = 6'd0;
    end

    if (por_low) begin
      if (17'(r_reg.por_q) == POR_QUAL - 17'd1) begin
        r_next.por_valid = 1'b1;
      end
      if (r_reg.por_q != 6'h3f) begin
        r_next.por_q = r_reg.por_q + 6'd1;
      end
    end else begin
      r_next.por_q = 6'd0;
    end

    case (r_reg.state)
      risq_pkg::RISQ_DRIVE: begin
        r_next.cnt = r_reg.cnt + 17'd1;
        if (r_reg.cnt == OUT_LOW - 17'd1) begin
          r_next.cnt = 17'd0;
          if (r_reg.soft_only) begin
            r_next.soft_drive = 1'b0;
            r_next.state      = risq_pkg::RISQ_IDLE;
          end else begin
            r_next.hard_drive = 1'b0;
            r_next.state      = risq_pkg::RISQ_GAP;
          end
        end
      end
      risq_pkg::RISQ_GAP: begin
        r_next.cnt = r_reg.cnt + 17'd1;
        if (r_reg.cnt == HS_GAP - 17'd1) begin
          r_next.cnt        = 17'd0;
          r_next.soft_drive = 1'b0;
          r_next.state      = risq_pkg::RISQ_DLL;
        end
      end
      risq_pkg::RISQ_DLL: begin
        r_next.cnt = r_reg.cnt + 17'd1;
        // lock after the ratio dependent count
        if (r_reg.cnt >= dll_limit - 17'd1) begin
          r_next.cnt        = 17'd0;
          r_next.dll_locked = 1'b1;
          r_next.state      = risq_pkg::RISQ_IDLE;
        end
      end
      risq_pkg::RISQ_IDLE: begin
        r_next.cnt = 17'd0;
      end
      default: begin
        r_next.state = risq_pkg::RISQ_IDLE;
        r_next.cnt   = 17'd0;
      end
    endcase

    // new flows: power-on over hard over soft; a hard or soft request does not restart a low phase already driving its pin
    if (por_low) begin
      r_next.state      = risq_pkg::RISQ_DRIVE;
      r_next.cnt        = 17'd0;
      r_next.hard_drive = 1'b1;
      r_next.soft_drive = 1'b1;
      r_next.soft_only  = 1'b0;
      r_next.dll_locked = 1'b0;
    end else if (por_release) begin
      // synced straps lag as much as the release, so setup margin is kept
      r_next.src_cap   = pin_syn[`RISQ_SYN_SRC_HI:`RISQ_SYN_SRC_LO];
      r_next.div_cap   = pin_syn[`RISQ_SYN_DIV];
      r_next.host_cap  = pin_syn[`RISQ_SYN_HOST];
      r_next.por_valid = 1'b0;
      r_next.ratio     = dll_ratio_sel;
    end else if (hard_start && !r_reg.hard_drive) begin
      r_next.state      = risq_pkg::RISQ_DRIVE;
      r_next.cnt        = 17'd0;
      r_next.hard_drive = 1'b1;
      r_next.soft_drive = 1'b1;
      r_next.soft_only  = 1'b0;
      r_next.dll_locked = 1'b0;
      r_next.ratio      = dll_ratio_sel;
    end else if (soft_start && !r_reg.soft_drive && !r_reg.hard_drive) begin
      r_next.state      = risq_pkg::RISQ_DRIVE;
      r_next.cnt        = 17'd0;
      r_next.soft_drive = 1'b1;
      r_next.soft_only  = 1'b1;
    end

    // strap drivers wait a period after hard release
    if (~pin_syn[`RISQ_SYN_HARD] | r_reg.hard_drive | por_low) begin
      r_next.strap_drive = 1'b0;
      r_next.strap_cnt   = 2'd0;
    end else if (!r_reg.strap_drive) begin
      r_next.strap_cnt = r_reg.strap_cnt + 2'd1;
      if (r_reg.strap_cnt >= STRAP_ON) begin
        r_next.strap_drive = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r_reg             <= '0;
      r_reg.state       <= risq_pkg::RISQ_IDLE;
      r_reg.src_cap     <= `RISQ_SRC_RST;
      r_reg.div_cap     <= `RISQ_DIV_RST;
      r_reg.ratio       <= `RISQ_RATIO_RST;
      r_reg.hard_drive  <= 1'b1;
      r_reg.soft_drive  <= 1'b1;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // open drain, the data value is always low
  assign hard_reset_n_out = 1'b0;
  assign soft_reset_n_out = 1'b0;
  assign hard_reset_n_oe  = r_reg.hard_drive;
  assign soft_reset_n_oe  = r_reg.soft_drive;

  // raw pin gates the enable; a synced path would take 20 ns, too slow for 4 ns
  assign reset_source_oe              = r_reg.strap_drive & hard_reset_n_in;
  assign input_clock_divide_select_oe = r_reg.strap_drive & hard_reset_n_in;
  // drivers stay off until hard release, so outside values are never fought
  assign reset_source_out              = r_reg.src_cap;
  assign input_clock_divide_select_out = r_reg.div_cap;

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  assign captured_reset_source = r_reg.src_cap;
  assign captured_clock_divide = r_reg.div_cap;
  // divider only matters in host mode
  assign sync_clock_divided    = r_reg.host_cap & r_reg.div_cap;
  assign dll_locked            = r_reg.dll_locked;
  assign flow_busy             = ~r_reg.state[0];

endmodule

// *** tb/risq_checker.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// sequencer port checks
// ----------------------------------------------------------------
module risq_checker #(
  parameter int DLL_LOCK_MIN_CYCLES = 8,
  parameter int DLL_LOCK_MAX_CYCLES = 128
) (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       power_on_reset_n,
  input wire logic       hard_reset_n_in,
  input wire logic       hard_reset_n_out,
  input wire logic       hard_reset_n_oe,
  input wire logic       soft_reset_n_out,
  input wire logic       soft_reset_n_oe,
  input wire logic       reset_source_oe,
  input wire logic       input_clock_divide_select_oe,
  input wire logic       hard_reset_req,
  input wire logic [2:0] captured_reset_source,
  input wire logic       captured_clock_divide,
  input wire logic       dll_locked,
  input wire logic       flow_busy
);
  // 20 bits outlast any run here, so no saturation is needed
  logic [19:0] h_cnt_reg;
  logic [19:0] s_cnt_reg;
  logic [19:0] g_cnt_reg;
  logic [19:0] l_cnt_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // cycles each pin is pulled, and cycles since each release
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      h_cnt_reg <= '0;
      s_cnt_reg <= '0;
      g_cnt_reg <= '0;
      l_cnt_reg <= '0;
    end else begin
      h_cnt_reg <= hard_reset_n_oe ? h_cnt_reg + 20'h0_0001 : '0;
      s_cnt_reg <= soft_reset_n_oe ? s_cnt_reg + 20'h0_0001 : '0;
      g_cnt_reg <= hard_reset_n_oe ? '0 : g_cnt_reg + 20'h0_0001;
      l_cnt_reg <= soft_reset_n_oe ? '0 : l_cnt_reg + 20'h0_0001;
    end
  end
  a_pins_low_only: assert property (!hard_reset_n_out && !soft_reset_n_out)
    else $error("reset pin driven high");
  a_strap_off: assert property (!hard_reset_n_in |-> !reset_source_oe && !input_clock_divide_select_oe)
    else $error("strap driven while hard low");
  a_strap_late: assert property ($rose(hard_reset_n_in) |-> !reset_source_oe ##1 !reset_source_oe)
    else $error("strap driven too soon");
  a_hard_hold: assert property ($fell(hard_reset_n_oe) |-> h_cnt_reg >= 20'h0_0200)
    else $error("hard pulse too short");
  a_soft_hold: assert property ($fell(soft_reset_n_oe) |-> s_cnt_reg >= 20'h0_0200)
    else $error("soft pulse too short");
  a_soft_gap: assert property ($fell(soft_reset_n_oe) |-> !hard_reset_n_oe && g_cnt_reg >= 20'h0_0010)
    else $error("soft released too early");
  a_lock_window: assert property ($rose(dll_locked) |-> !soft_reset_n_oe &&
    l_cnt_reg >= DLL_LOCK_MIN_CYCLES && l_cnt_reg <= DLL_LOCK_MAX_CYCLES)
    else $error("lock time out of window");
  a_strap_hold: assert property (($changed(captured_reset_source) || $changed(captured_clock_divide))
    |-> power_on_reset_n && $past(power_on_reset_n)) else $error("capture outside release");
  a_req_start: assert property (hard_reset_req && !hard_reset_n_oe |=>
    hard_reset_n_oe && soft_reset_n_oe && flow_busy && !dll_locked) else $error("request not taken");
endmodule

bind risq_top risq_checker #(.DLL_LOCK_MIN_CYCLES(DLL_LOCK_MIN_CYCLES),
  .DLL_LOCK_MAX_CYCLES(DLL_LOCK_MAX_CYCLES)) u_chk (.mclk(mclk), .reset_n(reset_n),
  .power_on_reset_n(power_on_reset_n), .hard_reset_n_in(hard_reset_n_in), .hard_reset_n_out(hard_reset_n_out),
  .hard_reset_n_oe(hard_reset_n_oe), .soft_reset_n_out(soft_reset_n_out), .soft_reset_n_oe(soft_reset_n_oe),
  .reset_source_oe(reset_source_oe), .input_clock_divide_select_oe(input_clock_divide_select_oe),
  .hard_reset_req(hard_reset_req), .captured_reset_source(captured_reset_source),
  .captured_clock_divide(captured_clock_divide), .dll_locked(dll_locked), .flow_busy(flow_busy));

// *** tb/risq_supervisor.sv ***
`timescale 1ns/1ps
// board supervisor: power-on reset, strap drivers, hard pull-down
module risq_supervisor (
  input  wire logic       mclk,
  input  wire logic       hard_wire,
  output logic            power_on_reset_n,
  output logic            hard_pull_n,
  output logic            host_pin,
  output logic      [2:0] src_pin,
  output logic            div_pin
);
  logic [2:0] src_val = 3'h0;
  logic       div_val = 1'b0;
  initial begin
    power_on_reset_n = 1'b1;
    hard_pull_n = 1'b1;
    host_pin = 1'b1;
  end
  // straps set at the start, so setup equals the pulse length
  task por_pulse(input int n, input logic h, input logic [2:0] s, input logic d);
    @(posedge mclk);
    host_pin <= h;
    src_val <= s;
    div_val <= d;
    power_on_reset_n <= 1'b0;
    repeat (n) @(posedge mclk);
    power_on_reset_n <= 1'b1;
  endtask
  // outside hard reset request of n cycles
  task hard_pulse(input int n);
    @(posedge mclk);
    hard_pull_n <= 1'b0;
    repeat (n) @(posedge mclk);
    hard_pull_n <= 1'b1;
  endtask
  // straps valid while hard is low; after release a toggling pattern
  always_ff @(posedge mclk) begin
    src_pin <= hard_wire ? ~src_pin : src_val;
    div_pin <= hard_wire ? ~div_pin : div_val;
  end
endmodule

// *** tb/tb_reset_initialization_sequencer.sv ***
`timescale 1ns/1ps
module tb_reset_initialization_sequencer;
  logic mclk, reset_n, ce, hard_reset_req, soft_reset_req, por_n, hard_pull_n, host_pin, div_pin;
  logic hard_oe, soft_oe, src_oe, div_oe, div_out, hard_out, soft_out, cap_div, divided, locked, busy;
  logic [1:0] dll_ratio_sel;
  logic [2:0] src_pin, src_out, cap_src;
  int         n_fail = 0;
  int         num_checks = 0;
  int         cyc = 0;
  // open-drain resets with pull-ups; straps shared with the supervisor
  wire logic       hard_wire = (hard_oe ? hard_out : 1'b1) & hard_pull_n;
  wire logic       soft_wire = soft_oe ? soft_out : 1'b1;
  wire logic [2:0] src_wire = src_oe ? src_out : src_pin;
  wire logic       div_wire = div_oe ? div_out : div_pin;

  risq_top #(.DLL_LOCK_MIN_CYCLES(8), .DLL_LOCK_MAX_CYCLES(128)) dut (.mclk(mclk), .reset_n(reset_n),
    .ce(ce), .power_on_reset_n(por_n), .hard_reset_n_in(hard_wire), .hard_reset_n_out(hard_out),
    .hard_reset_n_oe(hard_oe), .soft_reset_n_in(soft_wire), .soft_reset_n_out(soft_out),
    .soft_reset_n_oe(soft_oe), .pci_host_mode(host_pin), .reset_source_in(src_wire),
    .reset_source_out(src_out), .reset_source_oe(src_oe), .input_clock_divide_select_in(div_wire),
    .input_clock_divide_select_out(div_out), .input_clock_divide_select_oe(div_oe),
    .hard_reset_req(hard_reset_req), .soft_reset_req(soft_reset_req), .dll_ratio_sel(dll_ratio_sel),
    .captured_reset_source(cap_src), .captured_clock_divide(cap_div), .sync_clock_divided(divided),
    .dll_locked(locked), .flow_busy(busy));
  risq_supervisor u_sup (.mclk(mclk), .hard_wire(hard_wire), .power_on_reset_n(por_n),
    .hard_pull_n(hard_pull_n), .host_pin(host_pin), .src_pin(src_pin), .div_pin(div_pin));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // a hang counts as a mismatch; the run needs about 5000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      test_done();
    end
  end

  task chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task test_done();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wait_idle();
    for (int i = 0; i < 1500 && busy !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(17'(busy), 17'h0);
  endtask
  // power-on pulse, then captured straps and divided clock flag
  task t_por(input int n, input logic h, input logic [2:0] s, input logic d, input logic [2:0] es, input logic ed,
             input logic ec);
    u_sup.por_pulse(n, h, s, d);
    wait_idle();
    chk(17'(cap_src), 17'(es));
    chk(17'({cap_div, div_oe, div_out}), 17'({ec, 1'b1, ec}));
    chk(17'(divided), 17'(ed));
    chk(17'({src_oe, src_out}), 17'({1'b1, es}));
  endtask
  // hard request for ratio codes 0 to 2: soft release time after the request, and lock time
  task t_ratio();
    logic [16:0] n;
    for (int r = 0; r < 3; r++) begin
      @(posedge mclk);
      dll_ratio_sel <= 2'(r);
      hard_reset_req <= 1'b1;
      @(posedge mclk);
      hard_reset_req <= 1'b0;
      #1;
      chk(17'({hard_oe, soft_oe, busy, locked}), 17'h0_000e);
      n = '0;
      while (soft_oe !== 1'b0 && n < 17'h0_0800) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk(n, 17'h0_0210);
      n = '0;
      while (locked !== 1'b1 && n < 17'h0_0200) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk(n, 17'h0_0008 << (2 * r));
    end
  endtask
  // short pin pulse ignored; long one starts a flow, straps released
  task t_hard_pin();
    u_sup.hard_pulse(20);
    repeat (4) @(posedge mclk);
    #1;
    chk(17'(busy), 17'h0);
    fork
      u_sup.hard_pulse(40);
      begin
        repeat (3) @(posedge mclk);
        #1;
        chk(17'({src_oe, div_oe}), 17'h0);
      end
    join
    #1;
    chk(17'({hard_oe, busy}), 17'h0_0003);
    wait_idle();
  endtask
  // soft-only flow leaves hard alone
  task t_soft();
    logic [16:0] n;
    @(posedge mclk);
    soft_reset_req <= 1'b1;
    @(posedge mclk);
    soft_reset_req <= 1'b0;
    #1;
    chk(17'({hard_oe, soft_oe}), 17'h0_0001);
    // clock enable low for 10 edges: the low time stretches by exactly that much
    @(posedge mclk);
    ce <= 1'b0;
    repeat (10) @(posedge mclk);
    ce <= 1'b1;
    n = 17'h0_000b;
    while (soft_oe !== 1'b0 && n < 17'h0_0800) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n, 17'h0_020a);
    wait_idle();
  endtask

  // main sequence
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    hard_reset_req = 1'b0;
    soft_reset_req = 1'b0;
    dll_ratio_sel = 2'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    t_por(40, 1'b1, 3'h5, 1'b1, 3'h5, 1'b1, 1'b1);
    t_por(40, 1'b0, 3'h3, 1'b1, 3'h3, 1'b0, 1'b1);
    t_por(10, 1'b1, 3'h2, 1'b0, 3'h3, 1'b0, 1'b1);
    t_ratio();
    t_hard_pin();
    t_soft();
    test_done();
  end
endmodule
